// *** hw/adcm_mode_regs.sv ***
`timescale 1ns/1ns
// Summary of operation
// - 16-bit frame: R/W, 7-bit address, 8 data
// - Reset bit set clears all mode registers
// - Software reset briefly forces full sleep
// - Reset bit self-clears when write completes
// - Reset register write only, readback meaningless
// - Power field selects normal, nap or sleep
// - Clock invert bit flips output clock polarity
// - Delay field shifts output clock by eighths
// - Stabilizer bit turns duty cycle stabilizer on
// - Current field selects LVDS drive current
// - Termination bit enables termination, doubles current
// - Output disable bit tristates the data outputs (data_oe low); SDO is not affected
// - Mode field selects CMOS, DDR LVDS, DDR CMOS
// - Test codes off, all zeros, all ones
// - Checkerboard code alternates opposite bit patterns
// - Alternating code toggles all zeros, all ones
// - Test pattern overrides every other formatting mode
// - Alternate polarity forces offset binary format
// - Alternate polarity inverts odd data bits only
// - Scrambler bit enables output data randomizer
// - Coding bit selects two's complement output
module adcm_mode_regs (
    // System clock domain
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Serial programming port, serial clock domain
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe,
    // Raw conversion results, offset binary
    input wire logic [13:0] adc_sample,
    input wire logic adc_overflow,
    input wire logic adc_sample_valid,
    // Formatted output word
    output logic [13:0] sample_bits,
    output logic overflow_flag,
    output logic sample_out_valid,
    output logic data_oe,
    // Power control
    output logic [1:0] power_state_select,
    output logic chan1_nap,
    output logic chan2_nap,
    output logic full_sleep,
    // Output clock control
    output logic out_clock_invert,
    output logic [1:0] out_clock_delay_select,
    output logic duty_cycle_stabilizer,
    // Output driver control
    output logic [2:0] lvds_current_select,
    output logic lvds_internal_termination,
    output logic [13:0] lvds_drive_ua,
    output logic output_disable,
    output logic [1:0] output_format_select,
    // Data format control
    output logic [2:0] test_pattern_select,
    output logic alternate_polarity,
    output logic output_scrambler,
    output logic signed_coding_select
);

    // Frame state, cleared whenever select is high
    typedef struct packed {
        logic [4:0] cnt;
        logic [15:0] shift;
        logic rw;
    } adcm_frame_t;

    // Words handed to the system domain
    typedef struct packed {
        logic wr_tog;
        logic rd_tog;
        logic [14:0] wr_word;
        logic [6:0] rd_addr;
    } adcm_link_t;

    typedef struct packed {
        logic [2:0] wr_sync;
        logic [2:0] rd_sync;
        logic wr_seen;
        logic rd_seen;
        logic [7:0] power;
        logic [7:0] timing;
        logic [7:0] drive;
        logic [7:0] format;
        logic [7:0] rd_data;
        adcm_pkg::adcm_state_t st;
        logic [4:0] sleep_cnt;
        logic alt_phase;
        logic [14:0] word_out;
        logic out_valid;
    } adcm_core_t;

    adcm_frame_t frame_reg;
    adcm_frame_t frame_next;
    adcm_link_t link_reg;
    adcm_link_t link_next;
    adcm_core_t core_reg;
    adcm_core_t core_next;

    logic [15:0] shifted;
    logic frame_done;
    logic addr_done;
    logic read_phase;

    // Serial clock domain: shifting and handoff
    always_comb begin
        shifted = {frame_reg.shift[14:0], sdi};
        frame_next = frame_reg;
        link_next = link_reg;
        frame_done = 1'b0;
        addr_done = 1'b0;
        // Edges beyond the sixteenth are ignored
        if (frame_reg.cnt != adcm_pkg::FRAME_BITS) begin
            frame_next.shift = shifted;
            frame_next.cnt = frame_reg.cnt + 5'h01;
            if (frame_reg.cnt == 5'h00) begin
                frame_next.rw = sdi;
            end
            addr_done = (frame_next.cnt == adcm_pkg::ADDR_DONE_BITS);
            frame_done = (frame_next.cnt == adcm_pkg::FRAME_BITS);
        end
        if (addr_done && frame_reg.rw) begin
            link_next.rd_addr = shifted[6:0];
            link_next.rd_tog = ~link_reg.rd_tog;
        end
        // Reads never update a register
        if (frame_done && !shifted[adcm_pkg::WORD_RW_POS]) begin
            link_next.wr_word = shifted[adcm_pkg::WORD_ADDR_MSB:0];
            link_next.wr_tog = ~link_reg.wr_tog;
        end
    end

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            frame_reg <= '0;
        end else begin
            frame_reg <= frame_next;
        end
    end

    // Handoff words must survive idle select, so they clear only on system reset
    always_ff @(posedge sck or negedge nrst) begin
        if (!nrst) begin
            link_reg <= '0;
        end else if (!cs_n) begin
            link_reg <= link_next;
        end
    end

    // Read data goes out MSB first, bit changing after each rising edge
    always_comb begin
        read_phase = !cs_n && frame_reg.rw && frame_reg.cnt[3] && !frame_reg.cnt[4];
        sdo_o = 1'b0;
        sdo_oe = read_phase && !core_reg.rd_data[~frame_reg.cnt[2:0]];
    end

    logic wr_evt;
    logic rd_evt;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_value;
    logic [13:0] fmt;
    logic fmt_ovf;
    logic use_twos;
    logic [2:0] test_code;

    // System clock domain: register bank, sleep pulse, output formatting
    always_comb begin
        core_next = core_reg;
        wr_addr = link_reg.wr_word[adcm_pkg::WORD_ADDR_MSB:adcm_pkg::WORD_ADDR_LSB];
        wr_data = link_reg.wr_word[adcm_pkg::WORD_DATA_MSB:0];
        wr_evt = (core_reg.wr_sync[1] == core_reg.wr_sync[2]) &&
            (core_reg.wr_sync[2] != core_reg.wr_seen);
        rd_evt = (core_reg.rd_sync[1] == core_reg.rd_sync[2]) &&
            (core_reg.rd_sync[2] != core_reg.rd_seen);
        case (link_reg.rd_addr)
            adcm_pkg::ADDR_POWER_DOWN: rd_value = core_reg.power;
            adcm_pkg::ADDR_CLOCK_TIMING: rd_value = core_reg.timing;
            adcm_pkg::ADDR_DRIVE_MODE: rd_value = core_reg.drive;
            adcm_pkg::ADDR_DATA_FORMAT: rd_value = core_reg.format;
            // Reset register holds nothing to read back
            adcm_pkg::ADDR_SOFT_RESET: rd_value = adcm_pkg::READ_ZERO;
            default: rd_value = adcm_pkg::READ_ZERO;
        endcase
        test_code = core_reg.format[adcm_pkg::TEST_MSB:adcm_pkg::TEST_LSB];
        use_twos = core_reg.format[adcm_pkg::TWOS_BIT] &&
            !core_reg.format[adcm_pkg::ABP_BIT];
        fmt = adc_sample;
        fmt_ovf = adc_overflow;
        if (use_twos) begin
            fmt[adcm_pkg::SAMPLE_MSB] = ~fmt[adcm_pkg::SAMPLE_MSB];
        end
        if (core_reg.format[adcm_pkg::OUTPUT_SCRAMBLER_BIT]) begin
            fmt[13:1] = fmt[13:1] ^ {13{fmt[0]}};
        end
        if (core_reg.format[adcm_pkg::ABP_BIT]) begin
            fmt = fmt ^ adcm_pkg::ODD_BIT_MASK;
        end
        if (ce) begin
            core_next.wr_sync = {core_reg.wr_sync[1:0], link_reg.wr_tog};
            core_next.rd_sync = {core_reg.rd_sync[1:0], link_reg.rd_tog};
            if (rd_evt) begin
                core_next.rd_seen = core_reg.rd_sync[2];
                core_next.rd_data = rd_value;
            end
            case (core_reg.st)
                adcm_pkg::ST_RUN: begin
                end
                adcm_pkg::ST_SOFT_SLEEP: begin
                    if (core_reg.sleep_cnt == adcm_pkg::SLEEP_CNT_ONE) begin
                        core_next.st = adcm_pkg::ST_RUN;
                    end
                    core_next.sleep_cnt = core_reg.sleep_cnt - adcm_pkg::SLEEP_CNT_ONE;
                end
                default: begin
                    core_next.st = adcm_pkg::ST_RUN;
                end
            endcase
            if (wr_evt) begin
                core_next.wr_seen = core_reg.wr_sync[2];
                case (wr_addr)
                    adcm_pkg::ADDR_SOFT_RESET: begin
                        // The reset bit itself is never stored, so it reads as cleared
                        if (wr_data[adcm_pkg::SRST_BIT]) begin
                            core_next.power = adcm_pkg::REG_RESET;
                            core_next.timing = adcm_pkg::REG_RESET;
                            core_next.drive = adcm_pkg::REG_RESET;
                            core_next.format = adcm_pkg::REG_RESET;
                            core_next.st = adcm_pkg::ST_SOFT_SLEEP;
                            core_next.sleep_cnt = adcm_pkg::SOFT_SLEEP_CYCLES;
                        end
                    end
                    adcm_pkg::ADDR_POWER_DOWN: begin
                        core_next.power = wr_data & adcm_pkg::MASK_POWER;
                    end
                    adcm_pkg::ADDR_CLOCK_TIMING: begin
                        core_next.timing = wr_data & adcm_pkg::MASK_TIMING;
                    end
                    adcm_pkg::ADDR_DRIVE_MODE: begin
                        core_next.drive = wr_data & adcm_pkg::MASK_DRIVE;
                    end
                    adcm_pkg::ADDR_DATA_FORMAT: begin
                        core_next.format = wr_data & adcm_pkg::MASK_FORMAT;
                    end
                    default: begin
                    end
                endcase
            end
            core_next.out_valid = adc_sample_valid;
            if (adc_sample_valid) begin
                core_next.alt_phase = ~core_reg.alt_phase;
                // Test patterns replace the formatted word entirely
                case (test_code)
                    adcm_pkg::TP_ZEROS: core_next.word_out = adcm_pkg::PAT_ZEROS;
                    adcm_pkg::TP_ONES: core_next.word_out = adcm_pkg::PAT_ONES;
                    adcm_pkg::TP_CHECKER: begin
                        core_next.word_out = core_reg.alt_phase ?
                            adcm_pkg::PAT_CHECKER_B : adcm_pkg::PAT_CHECKER_A;
                    end
                    adcm_pkg::TP_ALTERNATE: begin
                        core_next.word_out = core_reg.alt_phase ?
                            adcm_pkg::PAT_ONES : adcm_pkg::PAT_ZEROS;
                    end
                    default: core_next.word_out = {fmt_ovf, fmt};
                endcase
            end
        end
        if (!nrst) begin
            core_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        core_reg <= core_next;
    end

    logic sleeping;
    logic [13:0] base_ua;

    always_comb begin
        sleeping = (power_state_select == adcm_pkg::PWR_SLEEP) ||
            (core_reg.st == adcm_pkg::ST_SOFT_SLEEP);
        // Unused current code falls back to the default current
        case (core_reg.drive[adcm_pkg::ILVDS_MSB:adcm_pkg::ILVDS_LSB])
            3'b000: base_ua = adcm_pkg::LVDS_UA_3P5;
            3'b001: base_ua = adcm_pkg::LVDS_UA_4P0;
            3'b010: base_ua = adcm_pkg::LVDS_UA_4P5;
            3'b100: base_ua = adcm_pkg::LVDS_UA_3P0;
            3'b101: base_ua = adcm_pkg::LVDS_UA_2P5;
            3'b110: base_ua = adcm_pkg::LVDS_UA_2P1;
            3'b111: base_ua = adcm_pkg::LVDS_UA_1P75;
            default: base_ua = adcm_pkg::LVDS_UA_3P5;
        endcase
    end

    assign power_state_select = core_reg.power[adcm_pkg::PWR_MSB:adcm_pkg::PWR_LSB];
    assign full_sleep = sleeping;
    assign chan1_nap = !sleeping &&
        (power_state_select == adcm_pkg::PWR_BOTH_NAP);
    assign chan2_nap = !sleeping &&
        ((power_state_select == adcm_pkg::PWR_BOTH_NAP) ||
        (power_state_select == adcm_pkg::PWR_CH2_NAP));
    assign out_clock_invert = core_reg.timing[adcm_pkg::OUT_CLOCK_INVERT_BIT];
    // Delay is only meaningful with the stabilizer on; the host keeps that pairing
    assign out_clock_delay_select =
        core_reg.timing[adcm_pkg::CLKDLY_MSB:adcm_pkg::CLKDLY_LSB];
    assign duty_cycle_stabilizer = core_reg.timing[adcm_pkg::DCS_BIT];
    assign lvds_current_select = core_reg.drive[adcm_pkg::ILVDS_MSB:adcm_pkg::ILVDS_LSB];
    assign lvds_internal_termination = core_reg.drive[adcm_pkg::TERM_BIT];
    assign lvds_drive_ua = lvds_internal_termination ?
        {base_ua[12:0], 1'b0} : base_ua;
    assign output_disable = core_reg.drive[adcm_pkg::OUTPUT_DISABLE_BIT];
    assign data_oe = !output_disable;
    assign output_format_select =
        (core_reg.drive[adcm_pkg::OMODE_MSB:adcm_pkg::OMODE_LSB] == adcm_pkg::FMT_UNUSED) ?
        adcm_pkg::FMT_CMOS : core_reg.drive[adcm_pkg::OMODE_MSB:adcm_pkg::OMODE_LSB];
    assign test_pattern_select = core_reg.format[adcm_pkg::TEST_MSB:adcm_pkg::TEST_LSB];
    assign alternate_polarity = core_reg.format[adcm_pkg::ABP_BIT];
    assign output_scrambler = core_reg.format[adcm_pkg::OUTPUT_SCRAMBLER_BIT];
    assign signed_coding_select = use_twos;
    assign sample_bits = core_reg.word_out[13:0];
    assign overflow_flag = core_reg.word_out[14];
    assign sample_out_valid = core_reg.out_valid;

endmodule

// *** hw/adcm_pkg.sv ***
package adcm_pkg;

    // Serial frame layout
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] ADDR_DONE_BITS = 5'h08;
    localparam int WORD_RW_POS = 15;
    localparam int WORD_ADDR_MSB = 14;
    localparam int WORD_ADDR_LSB = 8;
    localparam int WORD_DATA_MSB = 7;

    // Register addresses
    localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
    localparam logic [6:0] ADDR_POWER_DOWN = 7'h01;
    localparam logic [6:0] ADDR_CLOCK_TIMING = 7'h02;
    localparam logic [6:0] ADDR_DRIVE_MODE = 7'h03;
    localparam logic [6:0] ADDR_DATA_FORMAT = 7'h04;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Field positions
    localparam int SRST_BIT = 7;
    localparam int PWR_MSB = 1;
    localparam int PWR_LSB = 0;
    localparam int OUT_CLOCK_INVERT_BIT = 3;
    localparam int CLKDLY_MSB = 2;
    localparam int CLKDLY_LSB = 1;
    localparam int DCS_BIT = 0;
    localparam int ILVDS_MSB = 6;
    localparam int ILVDS_LSB = 4;
    localparam int TERM_BIT = 3;
    localparam int OUTPUT_DISABLE_BIT = 2;
    localparam int OMODE_MSB = 1;
    localparam int OMODE_LSB = 0;
    localparam int TEST_MSB = 5;
    localparam int TEST_LSB = 3;
    localparam int ABP_BIT = 2;
    localparam int OUTPUT_SCRAMBLER_BIT = 1;
    localparam int TWOS_BIT = 0;

    // Writable bits per register; unused bits read back as zero
    localparam logic [7:0] MASK_POWER = 8'h03;
    localparam logic [7:0] MASK_TIMING = 8'h0f;
    localparam logic [7:0] MASK_DRIVE = 8'h7f;
    localparam logic [7:0] MASK_FORMAT = 8'h3f;

    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_CH2_NAP = 2'b01,
        PWR_BOTH_NAP = 2'b10,
        PWR_SLEEP = 2'b11
    } adcm_power_t;

    typedef enum logic [1:0] {
        FMT_CMOS = 2'b00,
        FMT_DDR_LVDS = 2'b01,
        FMT_DDR_CMOS = 2'b10,
        FMT_UNUSED = 2'b11
    } adcm_format_t;

    typedef enum logic [2:0] {
        TP_OFF = 3'b000,
        TP_ZEROS = 3'b001,
        TP_ONES = 3'b011,
        TP_CHECKER = 3'b101,
        TP_ALTERNATE = 3'b111
    } adcm_test_t;

    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_SOFT_SLEEP = 1'b1
    } adcm_state_t;

    // Output word patterns, overflow flag in the top bit
    localparam logic [14:0] PAT_ZEROS = 15'h0000;
    localparam logic [14:0] PAT_ONES = 15'h7fff;
    localparam logic [14:0] PAT_CHECKER_A = 15'h5555;
    localparam logic [14:0] PAT_CHECKER_B = 15'h2aaa;
    localparam logic [13:0] ODD_BIT_MASK = 14'h2aaa;
    localparam int SAMPLE_MSB = 13;

    // LVDS driver current in microamps
    localparam logic [13:0] LVDS_UA_3P5 = 14'h0dac;
    localparam logic [13:0] LVDS_UA_4P0 = 14'h0fa0;
    localparam logic [13:0] LVDS_UA_4P5 = 14'h1194;
    localparam logic [13:0] LVDS_UA_3P0 = 14'h0bb8;
    localparam logic [13:0] LVDS_UA_2P5 = 14'h09c4;
    localparam logic [13:0] LVDS_UA_2P1 = 14'h0834;
    localparam logic [13:0] LVDS_UA_1P75 = 14'h06d6;

    // Sleep pulse applied by the software reset
    localparam int CLK_PERIOD_NS = 4;
    localparam int SOFT_SLEEP_NS = 100;
    localparam logic [4:0] SOFT_SLEEP_CYCLES =
        5'((SOFT_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] SLEEP_CNT_ONE = 5'h01;
    localparam logic [4:0] SLEEP_CNT_ZERO = 5'h00;

endpackage

// *** testbench/adcm_mode_regs_asserts.sv ***
`timescale 1ns/1ns
module adcm_mode_regs_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Sample path
    input wire logic [13:0] adc_sample,
    input wire logic adc_overflow,
    input wire logic adc_sample_valid,
    input wire logic [13:0] sample_bits,
    input wire logic overflow_flag,
    input wire logic data_oe,
    // Control fields
    input wire logic [1:0] power_state_select,
    input wire logic chan1_nap,
    input wire logic chan2_nap,
    input wire logic full_sleep,
    input wire logic [2:0] lvds_current_select,
    input wire logic lvds_internal_termination,
    input wire logic [13:0] lvds_drive_ua,
    input wire logic output_disable,
    input wire logic [1:0] output_format_select,
    input wire logic [2:0] test_pattern_select,
    input wire logic alternate_polarity,
    input wire logic output_scrambler,
    input wire logic signed_coding_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic v;
    logic [14:0] w;
    logic [13:0] ua;
    assign v = ce && adc_sample_valid;
    assign w = {overflow_flag, sample_bits};
    always_comb begin
        case (lvds_current_select)
            3'h1: ua = 14'h0fa0;
            3'h2: ua = 14'h1194;
            3'h4: ua = 14'h0bb8;
            3'h5: ua = 14'h09c4;
            3'h6: ua = 14'h0834;
            3'h7: ua = 14'h06d6;
            default: ua = 14'h0dac;
        endcase
    end
    property p_sleep; power_state_select == 2'b11 |-> full_sleep; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep code without sleep");
    property p_nap;
        !full_sleep |-> chan1_nap == (power_state_select == 2'b10)
            && chan2_nap == (power_state_select inside {2'b01, 2'b10});
    endproperty
    a_nap: assert property (p_nap) else $error("nap outputs wrong");
    property p_ua;
        lvds_drive_ua == 14'(ua * (lvds_internal_termination ? 2 : 1));
    endproperty
    a_ua: assert property (p_ua) else $error("drive current wrong");
    property p_oe; data_oe == !output_disable; endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
    property p_fmt; output_format_select != 2'b11; endproperty
    a_fmt: assert property (p_fmt) else $error("unused output mode shown");
    property p_abp; alternate_polarity |-> !signed_coding_select; endproperty
    a_abp: assert property (p_abp) else $error("signed coding under polarity");
    property p_raw;
        v && test_pattern_select == 3'b000 && !output_scrambler && !alternate_polarity |=>
            w == {$past(adc_overflow), $past(adc_sample) ^ {$past(signed_coding_select), 13'h0}};
    endproperty
    a_raw: assert property (p_raw) else $error("plain data wrong");
    property p_odd;
        v && test_pattern_select == 3'b000 && !output_scrambler && alternate_polarity |=>
            sample_bits == ($past(adc_sample) ^ 14'h2aaa);
    endproperty
    a_odd: assert property (p_odd) else $error("odd bit inversion wrong");
    property p_const;
        v && test_pattern_select inside {3'b001, 3'b011} |=>
            w == ($past(test_pattern_select[1]) ? 15'h7fff : 15'h0000);
    endproperty
    a_const: assert property (p_const) else $error("constant pattern wrong");
    property p_chk;
        v && test_pattern_select == 3'b101 |=> w == 15'h5555 || w == 15'h2aaa;
    endproperty
    a_chk: assert property (p_chk) else $error("checkerboard wrong");
    sequence s_alt; v && test_pattern_select == 3'b111; endsequence
    property p_alt; s_alt ##1 s_alt |=> w == ~$past(w); endproperty
    a_alt: assert property (p_alt) else $error("alternating pattern wrong");
    c_chk: cover property (v && test_pattern_select == 3'b101);
    c_soft: cover property (full_sleep && power_state_select == 2'b00);
    c_term: cover property (lvds_internal_termination && output_disable);
endmodule

// *** testbench/adcm_host_model.sv ***
`timescale 1ns/1ns
module adcm_host_model (
    // Serial lines
    output logic sck,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_oe
);
    // External pull-up unless the device pulls low
    wire sdo_line = !sdo_oe;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b1;
    end
    // Clocks n bits MSB first; edges past 16 carry junk and must be ignored
    task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        #37 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi = (i < 16) ? w[15 - i] : !sdi;
            #80;
            // Read bit is taken while it stands, just before the edge that advances it
            if (i >= 8 && i < 16) rd = {rd[6:0], sdo_line};
            sck = 1'b1;
            #80 sck = 1'b0;
        end
        #80 cs_n = 1'b1;
        sdi = !sdi;
        #80;
    endtask
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ns
module tb;
    logic clk, nrst, ce, sck, cs_n, sdi, sdo_o, sdo_oe, adc_overflow, adc_sample_valid;
    logic [13:0] adc_sample, sample_bits, lvds_drive_ua;
    logic overflow_flag, sample_out_valid, data_oe, chan1_nap, chan2_nap, full_sleep;
    logic [1:0] power_state_select, out_clock_delay_select, output_format_select;
    logic out_clock_invert, duty_cycle_stabilizer, lvds_internal_termination, output_disable;
    logic [2:0] lvds_current_select, test_pattern_select;
    logic alternate_polarity, output_scrambler, signed_coding_select;
    int n_errors = 0, checks = 0, hi = 0, seed = 32'h37e8d9d2;
    logic busy = 1'b1, ph = 1'b0;
    logic [7:0] fmt = 8'h00, rd;
    logic [14:0] exp_w;
    adcm_mode_regs DUT (.*);
    adcm_host_model host (.sck, .cs_n, .sdi, .sdo_oe);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        busy = 1'b1;
        host.xfer({1'b0, a, d}, 16, rd);
        repeat (8) @(posedge clk);
        if (a == 7'h04) fmt = d & 8'h3f;
        busy = 1'b0;
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        host.xfer({1'b1, a, 8'h00}, 16, rd);
        cmp({sdo_o, rd}, {1'b0, e});
    endtask
    function automatic logic [7:0] mask(logic [6:0] a);
        return a == 1 ? 8'h03 : a == 2 ? 8'h0f : a == 3 ? 8'h7f : 8'h3f;
    endfunction
    function automatic logic [13:0] ua_exp(logic [2:0] c, logic t);
        logic [13:0] u;
        u = c == 1 ? 14'h0fa0 : c == 2 ? 14'h1194 : c == 4 ? 14'h0bb8 : c == 5 ? 14'h09c4 :
            c == 6 ? 14'h0834 : c == 7 ? 14'h06d6 : 14'h0dac;
        return t ? 14'(u * 2) : u;
    endfunction
    function automatic logic [14:0] exp_word(logic [13:0] s, logic o, logic [7:0] f, logic p);
        logic [13:0] d;
        d = s;
        case (f[5:3])
            3'b001: return 15'h0000;
            3'b011: return 15'h7fff;
            3'b101: return p ? 15'h2aaa : 15'h5555;
            3'b111: return p ? 15'h7fff : 15'h0000;
            default: ;
        endcase
        if (f[0] && !f[2]) d[13] = !d[13];
        if (f[1]) d[13:1] = d[13:1] ^ {13{d[0]}};
        if (f[2]) d = d ^ 14'h2aaa;
        return {o, d};
    endfunction
    task automatic chk_ports(input logic [6:0] a, input logic [7:0] d);
        case (a)
            1: cmp(power_state_select, d[1:0]);
            2: cmp({out_clock_invert, out_clock_delay_select, duty_cycle_stabilizer}, d[3:0]);
            3: begin
                cmp({lvds_current_select, lvds_internal_termination, output_disable}, d[6:2]);
                cmp(data_oe, !d[2]);
                cmp(lvds_drive_ua, ua_exp(d[6:4], d[3]));
                cmp(output_format_select, d[1:0] == 3 ? 2'b00 : d[1:0]);
            end
            default: begin
                cmp({test_pattern_select, alternate_polarity, output_scrambler}, d[5:1]);
                cmp(signed_coding_select, d[0] && !d[2]);
            end
        endcase
    endtask
    always @(negedge clk) begin
        adc_sample = 14'($random(seed));
        adc_overflow = 1'($random(seed));
        adc_sample_valid = !busy && 1'($random(seed));
        ce = busy || (3'($random(seed)) != 3'h0);
    end
    always @(posedge clk) begin
        if (full_sleep === 1'b1) hi++;
        if (!nrst) begin
            ph = 1'b0;
        end else if (ce && adc_sample_valid) begin
            exp_w = exp_word(adc_sample, adc_overflow, fmt, ph);
            ph = !ph;
            #1 cmp({overflow_flag, sample_bits}, exp_w);
            cmp(sample_out_valid, 1'b1);
        end
    end
    initial begin
        #360000;
        n_errors++;
        finish_test();
    end
    initial begin
        logic [7:0] d;
        logic [6:0] a;
        nrst = 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        repeat (2) @(negedge clk);
        for (int i = 1; i < 6; i++) rdc(7'(i), 8'h00);
        for (int i = 0; i < 16; i++) begin
            a = 7'(1 + i % 4);
            d = 8'($random(seed));
            if (a == 2 && d[2:1] != 0) d[0] = 1'b1;
            if (a == 3) d[2] = 1'b0;
            wr(a, d);
            rdc(a, d & mask(a));
            chk_ports(a, d);
        end
        for (int p = 0; p < 4; p++) begin
            wr(1, 8'(p));
            cmp({full_sleep, chan1_nap, chan2_nap}, {p == 3, p == 2, p == 1 || p == 2});
        end
        for (int i = 0; i < 16; i++) begin
            d = 8'($random(seed));
            wr(3, d);
            chk_ports(3, d);
        end
        for (int k = 0; k < 32; k++) begin
            d = {2'b00, 5'(k), 1'($random(seed))};
            wr(4, d);
            chk_ports(4, d);
            repeat (40) @(posedge clk);
        end
        wr(2, 8'h00);
        host.xfer(16'h02ff, 12, rd);
        rdc(2, 8'h00);
        host.xfer(16'h0205, 20, rd);
        rdc(2, 8'h05);
        wr(1, 8'h00);
        busy = 1'b1;
        hi = 0;
        host.xfer(16'h0080, 16, rd);
        repeat (40) @(posedge clk);
        cmp(16'(hi), 16'(adcm_pkg::SOFT_SLEEP_CYCLES));
        fmt = 8'h00;
        busy = 1'b0;
        for (int i = 1; i < 5; i++) rdc(7'(i), 8'h00);
        hi = 0;
        wr(1, 8'h02);
        cmp({hi[13:0], power_state_select}, 16'h0002);
        finish_test();
    end
endmodule
bind adcm_mode_regs adcm_mode_regs_asserts u_chk (.*);
